/* File: src/ebcmt_pkg.sv */
package ebcmt_pkg;

    // Register offsets as printed, and the Avalon word index that each one maps to.
    localparam logic [23:0] OFS_TIMER_CONTROL = 24'hFFFF68;
    localparam logic [23:0] OFS_TIMER_FLAGS = 24'hFFFF6A;
    localparam logic [23:0] OFS_PERIOD_COMPARE = 24'hFFFF6C;
    localparam logic [23:0] OFS_LOW_WIDTH_COMPARE = 24'hFFFF6E;
    localparam logic [23:0] OFS_UP_COUNTER = 24'hFFFF70;
    localparam logic [7:0] IDX_TIMER_CONTROL = OFS_TIMER_CONTROL[7:0];
    localparam logic [7:0] IDX_TIMER_FLAGS = OFS_TIMER_FLAGS[7:0];
    localparam logic [7:0] IDX_PERIOD_COMPARE = OFS_PERIOD_COMPARE[7:0];
    localparam logic [7:0] IDX_LOW_WIDTH_COMPARE = OFS_LOW_WIDTH_COMPARE[7:0];
    localparam logic [7:0] IDX_UP_COUNTER = OFS_UP_COUNTER[7:0];
    // Channel 1 sits one index above the channel 0 copy of each register.
    localparam logic [7:0] IDX_CHAN1_STEP = 8'h01;

    // Reset values, then the counter limit and count step.
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_FLAGS = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'hFF;
    localparam logic [7:0] RST_UP_COUNTER = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // Timer control fields.
    localparam int CTL_MATCH_B_IRQ_ENABLE = 7;
    localparam int CTL_MATCH_A_IRQ_ENABLE = 6;
    localparam int CTL_OVERFLOW_IRQ_ENABLE = 5;
    localparam int CTL_CLEAR_SELECT_HI = 4;
    localparam int CTL_CLEAR_SELECT_LO = 3;
    localparam int CTL_CLOCK_SELECT_2 = 2;
    localparam int CTL_CLOCK_SELECT_0 = 0;

    // Flag and output register fields.
    localparam int STA_MATCH_B_FLAG = 7;
    localparam int STA_MATCH_A_FLAG = 6;
    localparam int STA_OVERFLOW_FLAG = 5;
    localparam int STA_CONVERSION_TRIGGER_ENABLE = 4;
    localparam int STA_MATCH_B_ACTION_HI = 3;
    localparam int STA_MATCH_B_ACTION_LO = 2;
    localparam int STA_MATCH_A_ACTION_HI = 1;
    localparam int STA_MATCH_A_ACTION_LO = 0;
    localparam int STA_FLAGS_LO = 5;
    localparam int STA_CTRL_HI = 4;

    // Prescaler ratios of the system clock.
    localparam int DIV_FAST = 8;
    localparam int DIV_MID = 64;
    localparam int DIV_SLOW = 8192;

    // Count clock selection.
    typedef enum logic [2:0] {
        CKS_STOP = 3'h0,
        CKS_DIV_FAST = 3'h1,
        CKS_DIV_MID = 3'h2,
        CKS_DIV_SLOW = 3'h3,
        CKS_CASCADE = 3'h4
    } ebcmt_clock_select_t;

    // Counter clear selection.
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_MATCH_A = 2'h1,
        CLR_MATCH_B = 2'h2,
        CLR_EXTERNAL = 2'h3
    } ebcmt_clear_select_t;

    // Output pin action on a compare match.
    typedef enum logic [1:0] {
        ACT_KEEP = 2'h0,
        ACT_LOW = 2'h1,
        ACT_HIGH = 2'h2,
        ACT_TOGGLE = 2'h3
    } ebcmt_action_t;

    // Register kinds reached through the bus.
    typedef enum logic [2:0] {
        KIND_NONE = 3'h0,
        KIND_CONTROL = 3'h1,
        KIND_FLAGS = 3'h2,
        KIND_CMP_A = 3'h3,
        KIND_CMP_B = 3'h4,
        KIND_COUNTER = 3'h5
    } ebcmt_kind_t;

endpackage : ebcmt_pkg

/* File: src/ebcmt_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none

module ebcmt_prescaler #(
    parameter int DIV_FAST = ebcmt_pkg::DIV_FAST,
    parameter int DIV_MID = ebcmt_pkg::DIV_MID,
    parameter int DIV_SLOW = ebcmt_pkg::DIV_SLOW
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // One-cycle enables, one per ratio.
    output logic o_tick_fast,
    output logic o_tick_mid,
    output logic o_tick_slow
);

    localparam int W = $clog2(DIV_SLOW);
    localparam logic [W-1:0] MASK_FAST = W'(DIV_FAST - 1);
    localparam logic [W-1:0] MASK_MID = W'(DIV_MID - 1);
    localparam logic [W-1:0] MASK_SLOW = W'(DIV_SLOW - 1);

    typedef struct packed {
        logic [W-1:0] count;
        logic fast;
        logic mid;
        logic slow;
    } ebcmt_psc_state_t;

    ebcmt_psc_state_t s;
    ebcmt_psc_state_t n;

    // Free-running count; each enable marks the last cycle of its period,
    // which stands for the falling edge of the divided clock.
    always_comb begin
        n = s;
        n.count = s.count + W'(1);
        n.fast = (s.count & MASK_FAST) == MASK_FAST;
        n.mid = (s.count & MASK_MID) == MASK_MID;
        n.slow = s.count == MASK_SLOW;
    end

    // State register.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_tick_fast = s.fast;
    assign o_tick_mid = s.mid;
    assign o_tick_slow = s.slow;

endmodule : ebcmt_prescaler

`default_nettype wire

/* File: src/ebcmt_top.sv */
`timescale 1ns/10ps
`default_nettype none

module ebcmt_top #(
    parameter int DIV_FAST = ebcmt_pkg::DIV_FAST,
    parameter int DIV_MID = ebcmt_pkg::DIV_MID,
    parameter int DIV_SLOW = ebcmt_pkg::DIV_SLOW
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Avalon-MM slave, word addressed.
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // External counter reset inputs, one per channel.
    input wire logic [1:0] i_ext_reset,
    // Timer output pins, one per channel.
    output logic [1:0] o_timer_output_pin,
    // Interrupt requests, one per source and channel.
    output logic [1:0] o_match_a_request,
    output logic [1:0] o_match_b_request,
    output logic [1:0] o_overflow_request,
    // Conversion start pulses, one per channel.
    output logic [1:0] o_conversion_start
);

    typedef struct packed {
        logic [1:0][7:0] timer_control;
        logic [1:0][7:0] timer_flags_and_output;
        logic [1:0][7:0] period_compare;
        logic [1:0][7:0] low_width_compare;
        logic [1:0][7:0] up_counter;
        logic [1:0] eq_a_prev;
        logic [1:0] eq_b_prev;
        logic [1:0] ext_prev;
        logic [1:0] pin;
        logic [1:0] req_a;
        logic [1:0] req_b;
        logic [1:0] req_ov;
        logic [1:0] conv;
        logic waitreq;
        logic [31:0] rdata;
    } ebcmt_state_t;

    ebcmt_state_t s;
    ebcmt_state_t next_s;

    logic tick_fast;
    logic tick_mid;
    logic tick_slow;

    // Prescaler that feeds every selectable internal count rate.
    ebcmt_prescaler #(
        .DIV_FAST(DIV_FAST),
        .DIV_MID(DIV_MID),
        .DIV_SLOW(DIV_SLOW)
    ) u_prescaler (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .o_tick_fast(tick_fast),
        .o_tick_mid(tick_mid),
        .o_tick_slow(tick_slow)
    );

    // Maps a word index to a register kind, with the channel bit masked off.
    function automatic ebcmt_pkg::ebcmt_kind_t kind_of(input logic [7:0] a);
        logic [7:0] b;
        b = a & ~ebcmt_pkg::IDX_CHAN1_STEP;
        if (b == ebcmt_pkg::IDX_TIMER_CONTROL) begin
            kind_of = ebcmt_pkg::KIND_CONTROL;
        end else if (b == ebcmt_pkg::IDX_TIMER_FLAGS) begin
            kind_of = ebcmt_pkg::KIND_FLAGS;
        end else if (b == ebcmt_pkg::IDX_PERIOD_COMPARE) begin
            kind_of = ebcmt_pkg::KIND_CMP_A;
        end else if (b == ebcmt_pkg::IDX_LOW_WIDTH_COMPARE) begin
            kind_of = ebcmt_pkg::KIND_CMP_B;
        end else if (b == ebcmt_pkg::IDX_UP_COUNTER) begin
            kind_of = ebcmt_pkg::KIND_COUNTER;
        end else begin
            kind_of = ebcmt_pkg::KIND_NONE;
        end
    endfunction : kind_of

    // Applies one compare-match action to the pin level.
    function automatic logic apply_action(input logic level, input logic [1:0] act);
        case (act)
            ebcmt_pkg::ACT_LOW: apply_action = 1'b0;
            ebcmt_pkg::ACT_HIGH: apply_action = 1'b1;
            ebcmt_pkg::ACT_TOGGLE: apply_action = ~level;
            default: apply_action = level;
        endcase
    endfunction : apply_action

    // Whole-block next state: bus, compare, count, flags, pin and requests.
    always_comb begin
        ebcmt_pkg::ebcmt_kind_t kind;
        logic lane0_ch1;
        logic req;
        logic accept;
        logic [1:0] wr_en;
        logic [1:0][7:0] wr_byte;
        logic [1:0] eq_a;
        logic [1:0] eq_b;
        logic [1:0] ev_a;
        logic [1:0] ev_b;
        logic [1:0] tick;
        logic [1:0] ovf;
        logic [1:0] clr;
        logic [2:0] cks;
        logic [1:0] ccl;
        logic [1:0][7:0] rd_byte;
        next_s = s;
        kind = kind_of(i_avs_address);
        lane0_ch1 = (i_avs_address & ebcmt_pkg::IDX_CHAN1_STEP) != 8'h00;
        req = i_avs_read | i_avs_write;
        accept = req & ~s.waitreq;
        wr_en = 2'b00;
        wr_byte = '0;
        eq_a = 2'b00;
        eq_b = 2'b00;
        ev_a = 2'b00;
        ev_b = 2'b00;
        tick = 2'b00;
        ovf = 2'b00;
        clr = 2'b00;
        cks = 3'h0;
        ccl = 2'h0;
        rd_byte = '0;

        // Byte lane steering: at a channel 0 index lane 1 reaches channel 1,
        // which makes every register pair one 16-bit word.
        if (kind != ebcmt_pkg::KIND_NONE) begin
            if (lane0_ch1) begin
                wr_en[1] = i_avs_write & i_avs_byteenable[0];
                wr_byte[1] = i_avs_writedata[7:0];
            end else begin
                wr_en[0] = i_avs_write & i_avs_byteenable[0];
                wr_byte[0] = i_avs_writedata[7:0];
                wr_en[1] = i_avs_write & i_avs_byteenable[1];
                wr_byte[1] = i_avs_writedata[15:8];
            end
        end

        // Equality detect, blocked while a write to that compare is pending.
        for (int c = 0; c < 2; c++) begin
            eq_a[c] = (s.up_counter[c] == s.period_compare[c])
                && !(wr_en[c] && kind == ebcmt_pkg::KIND_CMP_A);
            eq_b[c] = (s.up_counter[c] == s.low_width_compare[c])
                && !(wr_en[c] && kind == ebcmt_pkg::KIND_CMP_B);
            ev_a[c] = eq_a[c] & ~s.eq_a_prev[c];
            ev_b[c] = eq_b[c] & ~s.eq_b_prev[c];
            next_s.eq_a_prev[c] = eq_a[c];
            next_s.eq_b_prev[c] = eq_b[c];
        end

        // Count enables; cascade lets channel 1 count on channel 0 match A
        // and channel 0 count on channel 1 overflow.
        for (int k = 1; k >= 0; k--) begin
            cks = s.timer_control[k][ebcmt_pkg::CTL_CLOCK_SELECT_2:ebcmt_pkg::CTL_CLOCK_SELECT_0];
            ccl = s.timer_control[k][ebcmt_pkg::CTL_CLEAR_SELECT_HI:ebcmt_pkg::CTL_CLEAR_SELECT_LO];
            case (cks)
                ebcmt_pkg::CKS_DIV_FAST: tick[k] = tick_fast;
                ebcmt_pkg::CKS_DIV_MID: tick[k] = tick_mid;
                ebcmt_pkg::CKS_DIV_SLOW: tick[k] = tick_slow;
                ebcmt_pkg::CKS_CASCADE: tick[k] = (k == 1) ? ev_a[0] : ovf[1];
                default: tick[k] = 1'b0;
            endcase
            // At most one clear source applies, by the clear-select field; CLR_NONE selects none.
            case (ccl)
                ebcmt_pkg::CLR_MATCH_A: clr[k] = tick[k] && eq_a[k];
                ebcmt_pkg::CLR_MATCH_B: clr[k] = tick[k] && eq_b[k];
                ebcmt_pkg::CLR_EXTERNAL: clr[k] = i_ext_reset[k] & ~s.ext_prev[k];
                default: clr[k] = 1'b0;
            endcase
            ovf[k] = tick[k] && !clr[k] && s.up_counter[k] == ebcmt_pkg::COUNT_MAX;
        end

        // Per-channel registers, flags, pin and requests.
        for (int c = 0; c < 2; c++) begin
            next_s.ext_prev[c] = i_ext_reset[c];

            // A bus write wins over counting; a clear wins over an increment.
            if (accept && wr_en[c] && kind == ebcmt_pkg::KIND_COUNTER) begin
                next_s.up_counter[c] = wr_byte[c];
            end else if (clr[c]) begin
                next_s.up_counter[c] = ebcmt_pkg::RST_UP_COUNTER;
            end else if (tick[c]) begin
                next_s.up_counter[c] = s.up_counter[c] + ebcmt_pkg::COUNT_STEP;
            end

            if (accept && wr_en[c] && kind == ebcmt_pkg::KIND_CMP_A) begin
                next_s.period_compare[c] = wr_byte[c];
            end
            if (accept && wr_en[c] && kind == ebcmt_pkg::KIND_CMP_B) begin
                next_s.low_width_compare[c] = wr_byte[c];
            end
            if (accept && wr_en[c] && kind == ebcmt_pkg::KIND_CONTROL) begin
                next_s.timer_control[c] = wr_byte[c];
            end

            // Software writes the low control bits and may only clear flags
            // by writing zero; a flag set in the same cycle still wins.
            if (accept && wr_en[c] && kind == ebcmt_pkg::KIND_FLAGS) begin
                next_s.timer_flags_and_output[c][ebcmt_pkg::STA_CTRL_HI:0] =
                    wr_byte[c][ebcmt_pkg::STA_CTRL_HI:0];
                next_s.timer_flags_and_output[c][7:ebcmt_pkg::STA_FLAGS_LO] =
                    s.timer_flags_and_output[c][7:ebcmt_pkg::STA_FLAGS_LO]
                    & wr_byte[c][7:ebcmt_pkg::STA_FLAGS_LO];
            end
            if (ev_b[c]) begin
                next_s.timer_flags_and_output[c][ebcmt_pkg::STA_MATCH_B_FLAG] = 1'b1;
            end
            if (ev_a[c]) begin
                next_s.timer_flags_and_output[c][ebcmt_pkg::STA_MATCH_A_FLAG] = 1'b1;
            end
            if (ovf[c]) begin
                next_s.timer_flags_and_output[c][ebcmt_pkg::STA_OVERFLOW_FLAG] = 1'b1;
            end

            // Pin: match B action first, then match A, so A wins a tie.
            next_s.pin[c] = s.pin[c];
            if (ev_b[c]) begin
                next_s.pin[c] = apply_action(s.pin[c],
                    s.timer_flags_and_output[c][ebcmt_pkg::STA_MATCH_B_ACTION_HI:
                                                ebcmt_pkg::STA_MATCH_B_ACTION_LO]);
            end
            if (ev_a[c]) begin
                next_s.pin[c] = apply_action(next_s.pin[c],
                    s.timer_flags_and_output[c][ebcmt_pkg::STA_MATCH_A_ACTION_HI:
                                                ebcmt_pkg::STA_MATCH_A_ACTION_LO]);
            end

            // Requests follow the flags gated by their enables.
            next_s.req_b[c] = next_s.timer_flags_and_output[c][ebcmt_pkg::STA_MATCH_B_FLAG]
                & next_s.timer_control[c][ebcmt_pkg::CTL_MATCH_B_IRQ_ENABLE];
            next_s.req_a[c] = next_s.timer_flags_and_output[c][ebcmt_pkg::STA_MATCH_A_FLAG]
                & next_s.timer_control[c][ebcmt_pkg::CTL_MATCH_A_IRQ_ENABLE];
            next_s.req_ov[c] = next_s.timer_flags_and_output[c][ebcmt_pkg::STA_OVERFLOW_FLAG]
                & next_s.timer_control[c][ebcmt_pkg::CTL_OVERFLOW_IRQ_ENABLE];
            next_s.conv[c] = ev_a[c]
                & s.timer_flags_and_output[c][ebcmt_pkg::STA_CONVERSION_TRIGGER_ENABLE];

            // Read value of this channel for the addressed register kind.
            case (kind)
                ebcmt_pkg::KIND_CONTROL: rd_byte[c] = s.timer_control[c];
                ebcmt_pkg::KIND_FLAGS: rd_byte[c] = s.timer_flags_and_output[c];
                ebcmt_pkg::KIND_CMP_A: rd_byte[c] = s.period_compare[c];
                ebcmt_pkg::KIND_CMP_B: rd_byte[c] = s.low_width_compare[c];
                ebcmt_pkg::KIND_COUNTER: rd_byte[c] = s.up_counter[c];
                default: rd_byte[c] = 8'h00;
            endcase
        end

        // Bus handshake: one wait cycle, then the accept cycle. Read data
        // are captured as the request is first seen; unmapped reads give zero.
        next_s.waitreq = 1'b1;
        if (req && s.waitreq) begin
            next_s.waitreq = 1'b0;
            if (i_avs_read) begin
                if (lane0_ch1) begin
                    next_s.rdata = {24'h000000, rd_byte[1]};
                end else begin
                    next_s.rdata = {16'h0000, rd_byte[1], rd_byte[0]};
                end
            end
        end
    end

    // State register.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            s.timer_control <= {2{ebcmt_pkg::RST_TIMER_CONTROL}};
            s.timer_flags_and_output <= {2{ebcmt_pkg::RST_TIMER_FLAGS}};
            s.period_compare <= {2{ebcmt_pkg::RST_COMPARE}};
            s.low_width_compare <= {2{ebcmt_pkg::RST_COMPARE}};
            s.up_counter <= {2{ebcmt_pkg::RST_UP_COUNTER}};
            s.eq_a_prev <= 2'h0;
            s.eq_b_prev <= 2'h0;
            s.ext_prev <= 2'h0;
            s.pin <= 2'h0;
            s.req_a <= 2'h0;
            s.req_b <= 2'h0;
            s.req_ov <= 2'h0;
            s.conv <= 2'h0;
            s.waitreq <= 1'b1;
            s.rdata <= 32'h00000000;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign o_avs_readdata = s.rdata;
    assign o_avs_waitrequest = s.waitreq;
    assign o_timer_output_pin = s.pin;
    assign o_match_a_request = s.req_a;
    assign o_match_b_request = s.req_b;
    assign o_overflow_request = s.req_ov;
    assign o_conversion_start = s.conv;

endmodule : ebcmt_top

`default_nettype wire

/* File: tb/ebcmt_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the bus handshake and the request, pulse and pin outputs of the timer.
module ebcmt_checker (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Bus side.
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Timer side.
    input wire logic [1:0] o_timer_output_pin,
    input wire logic [1:0] o_match_a_request,
    input wire logic [1:0] o_match_b_request,
    input wire logic [1:0] o_overflow_request,
    input wire logic [1:0] o_conversion_start
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    answer_next_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus request not answered next cycle");
    wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    data_hold_a: assert property (!(i_avs_read && o_avs_waitrequest)
        |=> $stable(o_avs_readdata)) else $error("read data moved without a read");
    upper_zero_a: assert property (o_avs_readdata[31:16] == 16'h0000)
        else $error("read data above bit 15 not zero");
    reset_state_a: assert property ($rose(i_rstn) |-> o_timer_output_pin == 2'h0
        && o_avs_waitrequest && o_match_a_request == 2'h0) else $error("bad state after reset");
    conv_pulse_a: assert property (o_conversion_start[0] |=> !o_conversion_start[0])
        else $error("conversion start longer than one cycle");
    a_req_drop_a: assert property ($fell(o_match_a_request[0]) && $past(i_rstn)
        |-> $past(i_avs_write) || $past(i_avs_write, 2)) else $error("match A request fell");
    b_req_drop_a: assert property ($fell(o_match_b_request[0]) && $past(i_rstn)
        |-> $past(i_avs_write) || $past(i_avs_write, 2)) else $error("match B request fell");
    ovf_req_drop_a: assert property ($fell(o_overflow_request[0]) && $past(i_rstn)
        |-> $past(i_avs_write) || $past(i_avs_write, 2)) else $error("overflow request fell");
    // Main scenarios reached.
    cover property (i_avs_read && !o_avs_waitrequest);
    cover property ($rose(o_timer_output_pin[0]));
    cover property (o_conversion_start[0]);
endmodule : ebcmt_checker

bind ebcmt_top ebcmt_checker chk_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_timer_output_pin(o_timer_output_pin),
    .o_match_a_request(o_match_a_request), .o_match_b_request(o_match_b_request),
    .o_overflow_request(o_overflow_request), .o_conversion_start(o_conversion_start));
`default_nettype wire

/* File: tb/ebcmt_load_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ebcmt_load_model (
    // Clock and the pin that drives the load.
    input wire logic i_ref_clk,
    input wire logic i_pin,
    // Clocks spent in the last complete high and low portions.
    output logic [15:0] o_high_width,
    output logic [15:0] o_low_width
);
    logic [15:0] run_len;
    logic last_pin;
    // Starts with nothing measured.
    initial begin
        run_len = 16'h0001;
        last_pin = 1'b0;
        o_high_width = 16'h0000;
        o_low_width = 16'h0000;
    end
    // Records the length of each level when the pin changes.
    always @(posedge i_ref_clk) begin
        if (i_pin !== last_pin) begin
            if (last_pin) o_high_width <= run_len;
            else o_low_width <= run_len;
            run_len <= 16'h0001;
        end else begin
            run_len <= run_len + 16'h0001;
        end
        last_pin <= i_pin;
    end
endmodule : ebcmt_load_model
`default_nettype wire

/* File: tb/test_ebcmt_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_ebcmt_top;
    logic i_ref_clk, i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [7:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [3:0] i_avs_byteenable;
    logic [1:0] i_ext_reset, o_timer_output_pin, o_match_a_request, o_match_b_request;
    logic [1:0] o_overflow_request, o_conversion_start;
    logic [15:0] high_width, low_width, rd, first;
    logic [7:0] cfg_ctl [4] = '{8'hE9, 8'h09, 8'h09, 8'h11};
    logic [7:0] cfg_stat [4] = '{8'h19, 8'h06, 8'h03, 8'h0C};
    logic [15:0] cfg_high [4] = '{16'h0018, 16'h0010, 16'h0028, 16'h0010};
    logic [15:0] cfg_low [4] = '{16'h0010, 16'h0018, 16'h0028, 16'h0010};
    int n_fail, cmp_count, cycles, n_conv;

    ebcmt_top #(.DIV_MID(16), .DIV_SLOW(16)) dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_ext_reset(i_ext_reset), .o_timer_output_pin(o_timer_output_pin),
        .o_match_a_request(o_match_a_request), .o_match_b_request(o_match_b_request),
        .o_overflow_request(o_overflow_request), .o_conversion_start(o_conversion_start));
    ebcmt_load_model load_u (.i_ref_clk(i_ref_clk), .i_pin(o_timer_output_pin[0]),
        .o_high_width(high_width), .o_low_width(low_width));

    // Clock at 25 MHz.
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // Cuts a hung run short.
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    // Counts conversion start pulses on channel 0.
    always @(posedge i_ref_clk) begin
        if (o_conversion_start[0] === 1'b1) n_conv <= n_conv + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // One bus access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] data,
        input logic [3:0] be);
        i_avs_address <= idx;
        i_avs_writedata <= {16'h0000, data};
        i_avs_byteenable <= be;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        @(posedge i_ref_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
        rd = o_avs_readdata[15:0];
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_ref_clk);
    endtask : bus

    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // Main sequence.
    initial begin
        {i_rstn, i_avs_read, i_avs_write, i_avs_address, i_ext_reset} = '0;
        {i_avs_writedata, i_avs_byteenable} = '0;
        {n_fail, cmp_count, cycles, n_conv} = '0;
        repeat (20) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        @(posedge i_ref_clk);
        bus(0, ebcmt_pkg::IDX_TIMER_CONTROL, 16'h0000, 4'h3);
        check(rd, 16'h0000);
        bus(0, ebcmt_pkg::IDX_PERIOD_COMPARE, 16'h0000, 4'h3);
        check(rd, 16'hFFFF);
        bus(0, ebcmt_pkg::IDX_LOW_WIDTH_COMPARE, 16'h0000, 4'h3);
        check(rd, 16'hFFFF);
        bus(0, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h3);
        check(rd, 16'h0000);
        // Word writes with the clock stopped, then a stray write to an unmapped index.
        bus(1, ebcmt_pkg::IDX_UP_COUNTER, 16'h1234, 4'h3);
        bus(1, ebcmt_pkg::IDX_PERIOD_COMPARE, 16'h5AA5, 4'h3);
        bus(1, 8'h00, 16'hFFFF, 4'h3);
        repeat (40) @(posedge i_ref_clk);
        bus(0, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h3);
        check(rd, 16'h1234);
        bus(0, ebcmt_pkg::IDX_UP_COUNTER + ebcmt_pkg::IDX_CHAN1_STEP, 16'h0000, 4'h1);
        check(rd, 16'h0012);
        bus(0, ebcmt_pkg::IDX_PERIOD_COMPARE, 16'h0000, 4'h3);
        check(rd, 16'h5AA5);
        bus(0, 8'h00, 16'h0000, 4'h3);
        check(rd, 16'h0000);
        // Counting rate: two reads taken 80 clocks apart.
        bus(1, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h1);
        bus(1, ebcmt_pkg::IDX_TIMER_CONTROL, 16'h0001, 4'h1);
        bus(0, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h1);
        first = rd;
        repeat (77) @(posedge i_ref_clk);
        bus(0, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h1);
        check({8'h00, rd[7:0] - first[7:0]}, 16'h000A);
        // Pulse shapes with compare A 4 and compare B 1, one clearing mode and action set each.
        bus(1, ebcmt_pkg::IDX_PERIOD_COMPARE, 16'h0004, 4'h1);
        bus(1, ebcmt_pkg::IDX_LOW_WIDTH_COMPARE, 16'h0001, 4'h1);
        for (int k = 0; k < 4; k++) begin
            bus(1, ebcmt_pkg::IDX_TIMER_FLAGS, {8'h00, cfg_stat[k]}, 4'h1);
            bus(1, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h1);
            bus(1, ebcmt_pkg::IDX_TIMER_CONTROL, {8'h00, cfg_ctl[k]}, 4'h1);
            repeat (130) @(posedge i_ref_clk);
            check(high_width, cfg_high[k]);
            check(low_width, cfg_low[k]);
            check({15'h0000, o_match_a_request[0]}, {15'h0000, cfg_ctl[k][6]});
            check({15'h0000, o_match_b_request[0]}, {15'h0000, cfg_ctl[k][7]});
        end
        // Free run through the wrap with the overflow request enabled; stale flags cleared.
        bus(1, ebcmt_pkg::IDX_TIMER_CONTROL, 16'h0021, 4'h1);
        bus(1, ebcmt_pkg::IDX_TIMER_FLAGS, 16'h000C, 4'h1);
        bus(1, ebcmt_pkg::IDX_UP_COUNTER, 16'h00FE, 4'h1);
        repeat (30) @(posedge i_ref_clk);
        check({15'h0000, o_overflow_request[0]}, 16'h0001);
        bus(0, ebcmt_pkg::IDX_TIMER_FLAGS, 16'h0000, 4'h3);
        check(rd, 16'h00AC);
        bus(1, ebcmt_pkg::IDX_TIMER_FLAGS, 16'h000C, 4'h1);
        repeat (3) @(posedge i_ref_clk);
        check({15'h0000, o_overflow_request[0]}, 16'h0000);
        // Stopped counter cleared by a rising edge on the external reset input.
        bus(1, ebcmt_pkg::IDX_TIMER_CONTROL, 16'h0018, 4'h1);
        bus(1, ebcmt_pkg::IDX_UP_COUNTER, 16'h0055, 4'h1);
        i_ext_reset <= 2'b01;
        repeat (2) @(posedge i_ref_clk);
        i_ext_reset <= 2'b00;
        bus(0, ebcmt_pkg::IDX_UP_COUNTER, 16'h0000, 4'h1);
        check({8'h00, rd[7:0]}, 16'h0000);
        // Rewriting compare A with the counter's own value gives a fresh match.
        bus(1, ebcmt_pkg::IDX_PERIOD_COMPARE, 16'h0000, 4'h1);
        bus(1, ebcmt_pkg::IDX_TIMER_FLAGS, 16'h000C, 4'h1);
        bus(1, ebcmt_pkg::IDX_PERIOD_COMPARE, 16'h0000, 4'h1);
        bus(0, ebcmt_pkg::IDX_TIMER_FLAGS, 16'h0000, 4'h1);
        check(rd, 16'h004C);
        check(n_conv[15:0], 16'h0003);
        stop_test();
    end
endmodule : test_ebcmt_top
`default_nettype wire
